// ===== verification/exc_host_model.sv
// Purpose: Host tuning software model on the parameter port.
// Assumes: One request per cycle; read answer one cycle after rd.
// Notes: The host owns the link level; requests are held one edge.
`timescale 1ns/10ps
module exc_host_model (
  input wire logic clk_sys,
  output exc_pkg::par_req_t par_req,
  input wire logic [31:0] par_rdata_ff,
  input wire logic par_rvalid_ff,
  output logic link_up
);
  initial begin
    par_req = '0;
    link_up = 1'b0;
  end

  task automatic write_reg(input logic [7:0] id, input logic [31:0] d);
    @(posedge clk_sys);
    par_req <= '{wr: 1'b1, rd: 1'b0, id: id, wdata: d};
    @(posedge clk_sys);
    par_req <= '0;
  endtask

  // Answer is registered, so take it once that edge has landed
  task automatic read_reg(input logic [7:0] id, output logic [31:0] d,
                          output logic v);
    @(posedge clk_sys);
    par_req <= '{wr: 1'b0, rd: 1'b1, id: id, wdata: 32'h0000_0000};
    @(posedge clk_sys);
    par_req <= '0;
    #1;
    v = par_rvalid_ff;
    d = par_rdata_ff;
  endtask

  // Refresh sooner than the watchdog time or the mode drops
  task automatic keep_alive(input logic [7:0] m, input int n, input int gap);
    repeat (n) begin
      write_reg(exc_pkg::REG_MODE, {24'h00_0000, m});
      repeat (gap) @(posedge clk_sys);
    end
  endtask

  task automatic set_link(input logic up);
    @(posedge clk_sys);
    link_up <= up;
  endtask
endmodule

// ===== verification/tb.sv
// Purpose: Self-checking bench for the excitation selector.
// Assumes: Millisecond tick shortened to 10 clocks.
// Notes: One drive sample every 4 clocks.
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic clk_sys, sys_rst, link_up, par_rvalid_ff, rd_v;
  logic sample_tick = 1'b0;
  exc_pkg::par_req_t par_req;
  exc_pkg::exc_out_t exc_out;
  logic [31:0] par_rdata_ff, rd_d;
  logic [exc_pkg::AMP_W-1:0] cur_amp, vel_amp;
  logic [4:0] depth;
  logic [7:0] gap, mode_q;
  logic [1:0] tick_cnt = 2'h0;
  logic signed [15:0] act, oth, pk;
  logic sg [0:47];
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int ones;

  excitation_mode_watchdog #(.MS_TICK_CYCLES(10)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .par_req(par_req),
    .par_unused_ff(), .par_rdata_ff(par_rdata_ff),
    .par_rvalid_ff(par_rvalid_ff), .link_up(link_up),
    .sample_tick(sample_tick), .current_excitation_amplitude(cur_amp),
    .velocity_excitation_amplitude(vel_amp),
    .binary_sequence_depth(depth), .excitation_sample_gap(gap),
    .exc_out_ff(exc_out), .excitation_mode_select_ff(mode_q));

  exc_host_model host (.clk_sys(clk_sys), .par_req(par_req),
    .par_rdata_ff(par_rdata_ff), .par_rvalid_ff(par_rvalid_ff),
    .link_up(link_up));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    tick_cnt <= tick_cnt + 2'h1;
    sample_tick <= (tick_cnt == 2'h3);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic wr(input logic [7:0] id, input logic [31:0] d);
    host.write_reg(id, d);
  endtask

  task automatic chk_reg(input logic [7:0] id, input logic [31:0] e);
    host.read_reg(id, rd_d, rd_v);
    `CHK(rd_v, 1'b1)
    `CHK(rd_d, e)
  endtask

  task automatic next_sample();
    @(posedge clk_sys iff sample_tick);
    #1;
  endtask

  initial begin
    sys_rst = 1'b1;
    cur_amp = 15'h0064;
    vel_amp = 15'h00c8;
    depth = 5'h04;
    gap = 8'h01;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    chk_reg(exc_pkg::REG_MODE, 32'h0000_0000);
    chk_reg(exc_pkg::REG_WDOG, 32'h0000_0000);
    chk_reg(exc_pkg::REG_INJECT, 32'h0000_0000);
    chk_reg(8'h10, 32'h0000_0000);
    host.set_link(1'b1);
    repeat (6) @(posedge clk_sys);
    for (int i = 0; i < 3; i++) begin
      wr(exc_pkg::REG_INJECT, 32'(i));
      chk_reg(exc_pkg::REG_INJECT, 32'(i));
      for (int m = 0; m < 5; m++) begin
        wr(exc_pkg::REG_MODE, 32'(m));
        chk_reg(exc_pkg::REG_MODE, 32'(m));
        ones = 0;
        repeat (3) begin
          next_sample();
          pk = (i == 2) ? 16'(vel_amp) : 16'(cur_amp);
          act = (i == 1) ? exc_out.current : exc_out.velocity;
          ones += int'(act != 16'sh0000);
          oth = (i == 1) ? exc_out.velocity : exc_out.current;
          if (i == 0 || m == 0) begin
            `CHK(exc_out, 32'h0000_0000)
          end else if (m == 4) begin
            `CHK(exc_out, {16'(cur_amp), 16'h0000})
          end else if (m == 1) begin
            `CHK(oth, 16'h0000)
            `CHK(act == pk || act == -pk, 1'b1)
          end else begin
            `CHK(oth, 16'h0000)
            `CHK(act <= pk && act >= -pk, 1'b1)
          end
        end
        // Sine is zero at most once in any three steps
        if (m == 2 && i != 0) `CHK(ones > 0, 1'b1)
      end
    end
    wr(exc_pkg::REG_MODE, 32'h0000_0005);
    chk_reg(exc_pkg::REG_MODE, 32'h0000_0004);
    wr(exc_pkg::REG_INJECT, 32'h0000_0003);
    chk_reg(exc_pkg::REG_INJECT, 32'h0000_0002);
    wr(exc_pkg::REG_INJECT, 32'h0000_0001);
    for (int g = 1; g < 3; g++) begin
      gap <= 8'(g);
      wr(exc_pkg::REG_MODE, 32'h0000_0001);
      repeat (4) next_sample();
      ones = 0;
      for (int k = 0; k < 48; k++) begin
        next_sample();
        sg[k] = exc_out.current[15];
        ones += int'(sg[k]);
      end
      `CHK(ones > 0 && ones < 48, 1'b1)
      for (int k = 0; k < 32; k++) `CHK(sg[k], sg[k + 16 / g])
      // A half-length repeat would also pass the check above
      ones = 0;
      for (int k = 0; k < 32; k++) ones += int'(sg[k] != sg[k + 8 / g]);
      `CHK(ones > 0, 1'b1)
    end
    host.set_link(1'b0);
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK(mode_q, 8'h00)
    wr(exc_pkg::REG_MODE, 32'h0000_0001);
    chk_reg(exc_pkg::REG_MODE, 32'h0000_0000);
    next_sample();
    `CHK(exc_out, 32'h0000_0000)
    host.set_link(1'b1);
    repeat (6) @(posedge clk_sys);
    wr(exc_pkg::REG_WDOG, 32'h1000_0000);
    chk_reg(exc_pkg::REG_WDOG, 32'h1000_0000);
    wr(exc_pkg::REG_WDOG, 32'h1000_0001);
    chk_reg(exc_pkg::REG_WDOG, 32'h1000_0000);
    wr(exc_pkg::REG_WDOG, 32'h0000_0003);
    host.keep_alive(8'h02, 5, 20);
    chk_reg(exc_pkg::REG_MODE, 32'h0000_0002);
    // Exactly 3 ms after the last refresh; the clear waits for a sample
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK(mode_q, 8'h02)
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK(mode_q, 8'h00)
    wr(exc_pkg::REG_WDOG, 32'h0000_0000);
    wr(exc_pkg::REG_MODE, 32'h0000_0001);
    repeat (100) @(posedge clk_sys);
    #1;
    `CHK(mode_q, 8'h01)
    print_verdict();
  end
endmodule

// ===== verilog/exc_lfsr.sv
// Purpose: Galois shift register used as a pseudo-random source.
// Assumes: Taps give a maximal sequence; seed is nonzero.
// Notes: Restart has priority over step.
`timescale 1ns/10ps
module exc_lfsr #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] TAPS = '1,
  parameter logic [WIDTH-1:0] SEED = '1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic restart,
  input wire logic step,
  output logic [WIDTH-1:0] state_ff
);

  logic [WIDTH-1:0] nxt_state;

  always_comb begin
    nxt_state = state_ff >> 1;
    if (state_ff[0]) begin
      nxt_state = (state_ff >> 1) ^ TAPS;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || restart) begin
      state_ff <= SEED;
    end else if (step) begin
      state_ff <= nxt_state;
    end
  end

endmodule

// ===== verilog/exc_pkg.sv
// Purpose: Shared constants and types of the excitation selector.
// Assumes: 100 MHz system clock.
// Notes: Parameter ids double as the command-port register offsets.
package exc_pkg;

  localparam logic [7:0] REG_INJECT = 8'h2c;
  localparam logic [7:0] REG_MODE = 8'h2e;
  localparam logic [7:0] REG_WDOG = 8'h30;

  localparam logic [7:0] INJECT_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [31:0] WDOG_RESET = 32'h0000_0000;
  localparam logic [7:0] INJECT_MAX = 8'h02;
  localparam logic [7:0] MODE_MAX = 8'h04;
  localparam logic [31:0] WDOG_MAX = 32'h1000_0000;

  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_PRB = 3'b001,
    MODE_SINE = 3'b010,
    MODE_NOISE = 3'b011,
    MODE_OFFSET = 3'b100
  } mode_t;

  typedef enum logic [1:0] {
    INJ_NONE = 2'b00,
    INJ_CURRENT = 2'b01,
    INJ_VELOCITY = 2'b10
  } inject_t;

  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

  localparam int AMP_W = 15;
  localparam int OUT_W = 16;
  localparam int PRB_W = 20;
  localparam logic [PRB_W-1:0] PRB_TAPS = 20'h9_0000;
  localparam logic [PRB_W-1:0] PRB_SEED = 20'h0_0001;
  localparam int NOISE_W = 16;
  localparam logic [NOISE_W-1:0] NOISE_TAPS = 16'hb400;
  localparam logic [NOISE_W-1:0] NOISE_SEED = 16'hace1;
  localparam int Q_SHIFT = 15;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] id;
    logic [31:0] wdata;
  } par_req_t;

  typedef struct packed {
    logic signed [OUT_W-1:0] current;
    logic signed [OUT_W-1:0] velocity;
  } exc_out_t;

  // Sixteen-step sine in Q15; coarse but cheap
  function automatic logic signed [15:0] sine_q15(input logic [3:0] idx);
    logic signed [15:0] v;
    v = 16'sh0000;
    unique case (idx)
      4'h0, 4'h8: v = 16'sh0000;
      4'h1, 4'h7: v = 16'sh30fb;
      4'h2, 4'h6: v = 16'sh5a82;
      4'h3, 4'h5: v = 16'sh7641;
      4'h4: v = 16'sh7fff;
      4'h9, 4'hf: v = 16'shcf05;
      4'ha, 4'he: v = 16'sha57e;
      4'hb, 4'hd: v = 16'sh89bf;
      4'hc: v = 16'sh8001;
    endcase
    return v;
  endfunction

endpackage

// ===== verilog/excitation_mode_watchdog.sv
// Purpose: Excitation source select, waveform scaling and mode watchdog.
// Assumes: sample_tick is a one-cycle pulse per drive sample.
// Notes: Amplitudes, sequence depth and gap arrive as plain inputs.
// Operation
// - Inject point 0 means none, 1 the current loop, 2 velocity.
// - The mode takes 0 to 4: off, binary sequence, sine, noise, offset.
// - Mode 0 gives no excitation at all.
// - A lost link forces the mode to off.
// - Peak amplitude is the current or velocity one per inject point.
// - Mode 1 sits at plus or minus peak, sign from the sequence.
// - The sequence repeats after two to the depth over gap samples.
// - Mode 3 gives a random value between minus and plus the peak.
// - Mode 4 applies a torque offset equal to the current amplitude.
// - Watchdog time zero leaves the mode alone.
// - A nonzero time clears the mode after that many ms have passed.
// - A nonzero mode write restarts the watchdog; the host repeats it.
// - The watchdog time is in ms and accepts 0 to 268,435,456.
`timescale 1ns/10ps
module excitation_mode_watchdog #(
  parameter int MS_TICK_CYCLES = exc_pkg::MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire exc_pkg::par_req_t par_req,
  output exc_pkg::par_req_t par_unused_ff,
  output logic [31:0] par_rdata_ff,
  output logic par_rvalid_ff,
  input wire logic link_up,
  input wire logic sample_tick,
  input wire logic [exc_pkg::AMP_W-1:0] current_excitation_amplitude,
  input wire logic [exc_pkg::AMP_W-1:0] velocity_excitation_amplitude,
  input wire logic [4:0] binary_sequence_depth,
  input wire logic [7:0] excitation_sample_gap,
  output exc_pkg::exc_out_t exc_out_ff,
  output logic [7:0] excitation_mode_select_ff
);

  localparam int OW = exc_pkg::OUT_W;
  localparam int PW = exc_pkg::PRB_W;

  logic [7:0] excitation_inject_point_ff;
  logic [31:0] excitation_watchdog_time_ff;
  logic link_meta_ff;
  logic link_s2_ff;
  logic link_s3_ff;
  logic link_ok_ff;
  logic [31:0] ms_div_ff;
  logic ms_tick;
  logic [31:0] elapsed_ff;
  logic [PW-1:0] prb_cnt_ff;
  logic [3:0] sine_idx_ff;
  logic [PW-1:0] prb_state;
  logic [exc_pkg::NOISE_W-1:0] noise_state;
  logic wr_mode;
  logic mode_ok;
  logic start_wdog;
  logic expired;
  logic prb_wrap;
  logic [PW:0] prb_period;
  logic [7:0] gap_eff;
  logic [exc_pkg::AMP_W-1:0] peak;
  logic signed [OW-1:0] peak_s;
  logic signed [OW-1:0] wave;
  logic signed [31:0] prod;
  exc_pkg::exc_out_t nxt_out;

  // Unused echo port kept quiet
  always_ff @(posedge clk_sys) begin
    par_unused_ff <= '0;
  end

  // Link level crosses from outside; agree of stages 2 and 3 counts
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      link_meta_ff <= 1'b0;
      link_s2_ff <= 1'b0;
      link_s3_ff <= 1'b0;
      link_ok_ff <= 1'b0;
    end else begin
      link_meta_ff <= link_up;
      link_s2_ff <= link_meta_ff;
      link_s3_ff <= link_s2_ff;
      if (link_s2_ff == link_s3_ff) begin
        link_ok_ff <= link_s3_ff;
      end
    end
  end

  assign wr_mode = par_req.wr && par_req.id == exc_pkg::REG_MODE;
  assign mode_ok = par_req.wdata <= 32'(exc_pkg::MODE_MAX);
  assign start_wdog = wr_mode && mode_ok && link_ok_ff
                      && par_req.wdata != 32'h0000_0000;

  // Prescaler restarts with the watchdog so the first ms is whole
  always_ff @(posedge clk_sys) begin
    if (sys_rst || start_wdog || ms_tick) begin
      ms_div_ff <= '0;
    end else begin
      ms_div_ff <= ms_div_ff + 32'h0000_0001;
    end
  end
  assign ms_tick = ms_div_ff == 32'(MS_TICK_CYCLES - 1);

  always_ff @(posedge clk_sys) begin
    if (sys_rst || start_wdog) begin
      elapsed_ff <= '0;
    end else if (ms_tick && excitation_mode_select_ff != 8'h00
                 && elapsed_ff != 32'hffff_ffff) begin
      elapsed_ff <= elapsed_ff + 32'h0000_0001;
    end
  end

  assign expired = excitation_mode_select_ff != 8'h00
                   && excitation_watchdog_time_ff != 32'h0000_0000
                   && elapsed_ff >= excitation_watchdog_time_ff;

  // Host write wins over a watchdog clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      excitation_mode_select_ff <= exc_pkg::MODE_RESET;
    end else if (!link_ok_ff) begin
      excitation_mode_select_ff <= exc_pkg::MODE_RESET;
    end else if (wr_mode && mode_ok) begin
      excitation_mode_select_ff <= par_req.wdata[7:0];
    end else if (expired && sample_tick) begin
      excitation_mode_select_ff <= exc_pkg::MODE_RESET;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      excitation_inject_point_ff <= exc_pkg::INJECT_RESET;
    end else if (par_req.wr && par_req.id == exc_pkg::REG_INJECT
                 && par_req.wdata <= 32'(exc_pkg::INJECT_MAX)) begin
      excitation_inject_point_ff <= par_req.wdata[7:0];
    end
  end

  // Out-of-range times are dropped, leaving the old value
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      excitation_watchdog_time_ff <= exc_pkg::WDOG_RESET;
    end else if (par_req.wr && par_req.id == exc_pkg::REG_WDOG
                 && par_req.wdata <= exc_pkg::WDOG_MAX) begin
      excitation_watchdog_time_ff <= par_req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      par_rdata_ff <= '0;
      par_rvalid_ff <= 1'b0;
    end else begin
      par_rvalid_ff <= par_req.rd;
      unique case (par_req.id)
        exc_pkg::REG_INJECT: par_rdata_ff <= {24'h00_0000,
                                              excitation_inject_point_ff};
        exc_pkg::REG_MODE: par_rdata_ff <= {24'h00_0000,
                                            excitation_mode_select_ff};
        exc_pkg::REG_WDOG: par_rdata_ff <= excitation_watchdog_time_ff;
        default: par_rdata_ff <= '0;
      endcase
    end
  end

  // Zero gap would divide by zero; treated as one
  assign gap_eff = excitation_sample_gap == 8'h00 ? 8'h01
                   : excitation_sample_gap;
  assign prb_period = (PW+1)'((21'h00_0001 << binary_sequence_depth)
                              / {13'h0000, gap_eff});
  assign prb_wrap = sample_tick && ({1'b0, prb_cnt_ff} + 21'h00_0001
                                    >= prb_period);

  always_ff @(posedge clk_sys) begin
    if (sys_rst || prb_wrap) begin
      prb_cnt_ff <= '0;
    end else if (sample_tick) begin
      prb_cnt_ff <= prb_cnt_ff + 20'h0_0001;
    end
  end

  exc_lfsr #(
    .WIDTH(PW),
    .TAPS(exc_pkg::PRB_TAPS),
    .SEED(exc_pkg::PRB_SEED)
  ) u_prb (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .restart(prb_wrap),
    .step(sample_tick),
    .state_ff(prb_state)
  );

  exc_lfsr #(
    .WIDTH(exc_pkg::NOISE_W),
    .TAPS(exc_pkg::NOISE_TAPS),
    .SEED(exc_pkg::NOISE_SEED)
  ) u_noise (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .restart(1'b0),
    .step(sample_tick),
    .state_ff(noise_state)
  );

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sine_idx_ff <= '0;
    end else if (sample_tick) begin
      sine_idx_ff <= sine_idx_ff + 4'h1;
    end
  end

  assign peak = excitation_inject_point_ff == 8'h02
                ? velocity_excitation_amplitude
                : current_excitation_amplitude;
  assign peak_s = signed'({1'b0, peak});

  always_comb begin
    wave = '0;
    prod = '0;
    unique case (exc_pkg::mode_t'(excitation_mode_select_ff[2:0]))
      exc_pkg::MODE_OFF: wave = '0;
      exc_pkg::MODE_PRB: wave = prb_state[0] ? peak_s : -peak_s;
      exc_pkg::MODE_SINE: begin
        prod = exc_pkg::sine_q15(sine_idx_ff) * peak_s;
        wave = OW'(prod >>> exc_pkg::Q_SHIFT);
      end
      exc_pkg::MODE_NOISE: begin
        prod = signed'(noise_state) * peak_s;
        wave = OW'(prod >>> exc_pkg::Q_SHIFT);
      end
      exc_pkg::MODE_OFFSET: wave = '0;
      default: wave = '0;
    endcase
  end

  always_comb begin
    nxt_out = '0;
    if (excitation_mode_select_ff == 8'h04
        && excitation_inject_point_ff != 8'h00) begin
      nxt_out.current = signed'({1'b0, current_excitation_amplitude});
    end else begin
      unique case (exc_pkg::inject_t'(excitation_inject_point_ff[1:0]))
        exc_pkg::INJ_NONE: nxt_out = '0;
        exc_pkg::INJ_CURRENT: nxt_out.current = wave;
        exc_pkg::INJ_VELOCITY: nxt_out.velocity = wave;
        default: nxt_out = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      exc_out_ff <= '0;
    end else if (sample_tick) begin
      exc_out_ff <= nxt_out;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  property p_inject_range;
    excitation_inject_point_ff <= exc_pkg::INJECT_MAX;
  endproperty
  a_inject_range: assert property (p_inject_range)
    else $error("inject point out of range");

  property p_mode_range;
    excitation_mode_select_ff <= exc_pkg::MODE_MAX;
  endproperty
  a_mode_range: assert property (p_mode_range)
    else $error("mode out of range");

  property p_off_silent;
    sample_tick && excitation_mode_select_ff == 8'h00 |=> exc_out_ff == '0;
  endproperty
  a_off_silent: assert property (p_off_silent)
    else $error("excitation present with mode off");

  property p_link_off;
    !link_ok_ff |=> excitation_mode_select_ff == 8'h00;
  endproperty
  a_link_off: assert property (p_link_off)
    else $error("mode not forced off by lost link");

  property p_prb_level;
    sample_tick && excitation_mode_select_ff == 8'h01
    && excitation_inject_point_ff == 8'h02
    |=> exc_out_ff.velocity == $past(peak_s)
        || exc_out_ff.velocity == -$past(peak_s);
  endproperty
  a_prb_level: assert property (p_prb_level)
    else $error("sequence output not at peak");

  property p_noise_bound;
    sample_tick && excitation_mode_select_ff == 8'h03
    && excitation_inject_point_ff == 8'h01
    |=> exc_out_ff.current <= $past(peak_s)
        && exc_out_ff.current >= -$past(peak_s);
  endproperty
  a_noise_bound: assert property (p_noise_bound)
    else $error("noise beyond peak");

  property p_offset;
    sample_tick && excitation_mode_select_ff == 8'h04
    && excitation_inject_point_ff != 8'h00
    |=> exc_out_ff.current
        == signed'({1'b0, $past(current_excitation_amplitude)})
        && exc_out_ff.velocity == '0;
  endproperty
  a_offset: assert property (p_offset)
    else $error("offset not equal to current amplitude");

  property p_no_wdog;
    excitation_watchdog_time_ff == 32'h0000_0000 && link_ok_ff
    && !par_req.wr |=> $stable(excitation_mode_select_ff);
  endproperty
  a_no_wdog: assert property (p_no_wdog)
    else $error("mode changed with watchdog disabled");

  property p_expire;
    expired && sample_tick && !par_req.wr
    |=> excitation_mode_select_ff == 8'h00;
  endproperty
  a_expire: assert property (p_expire)
    else $error("watchdog expiry did not clear mode");

  property p_restart;
    start_wdog |=> elapsed_ff == 32'h0000_0000 && ms_div_ff == '0
      ##1 elapsed_ff == 32'h0000_0000;
  endproperty
  a_restart: assert property (p_restart)
    else $error("mode write did not restart watchdog");

  property p_time_range;
    par_req.wr && par_req.id == exc_pkg::REG_WDOG
    && par_req.wdata > exc_pkg::WDOG_MAX
    |=> $stable(excitation_watchdog_time_ff);
  endproperty
  a_time_range: assert property (p_time_range)
    else $error("out-of-range watchdog time taken");

  property p_none_zero;
    sample_tick && excitation_inject_point_ff == 8'h00
    |=> exc_out_ff == '0;
  endproperty
  a_none_zero: assert property (p_none_zero)
    else $error("excitation with no inject point");

endmodule
